//--- include/scusm_pkg.sv
// Constants and types for the serial comms block (UART RX/TX, SPI master).
// Assumes a single clock domain; bit clock arrives as a plain input.
package scusm_pkg;

  // ****************************************************************
  // Function select
  // ****************************************************************
  localparam logic [1:0] FN_RX = 2'h0;
  localparam logic [1:0] FN_TX = 2'h1;
  localparam logic [1:0] FN_SPI = 2'h2;

  // ****************************************************************
  // Status bit positions and reset values
  // ****************************************************************
  localparam int ST_TXE = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RXF = 2;
  localparam int ST_PE = 3;
  localparam int ST_FE = 4;
  localparam int ST_OVR = 5;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] STATUS_KEEP = 8'h05;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ****************************************************************
  // Timing counts, in bit clock ticks or data bits
  // ****************************************************************
  localparam logic [2:0] OVERSAMPLE_LAST = 3'h7;
  localparam logic [2:0] MID_SAMPLE = 3'h3;
  localparam logic [3:0] DATA_BIT_LAST = 4'h7;
  localparam logic [3:0] SPI_EDGE_LAST = 4'hF;

  // ****************************************************************
  // Engine states, Gray coded along the frame
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP = 3'h6
  } scusm_state_t;

endpackage

//--- verilog/scusm_top.sv
// Serial comms block: UART receiver, UART transmitter or SPI master.
// Assumes the selected bit clock is a slow input sampled on i_clk, and
// that CPU strobes are one-cycle pulses on i_clk.

// What this block does
// - Receiver interrupt while receive holding byte is unread, if enabled.
// - Status read clears all bits but receive-full and holding-empty; data read clears receive-full.
// - Receive interrupt stays until holding byte read; no extra interrupts.
// - Missing stop bit flags framing error; low may start next frame.
// - Transmitter sends eight-bit words only, never chained.
// - Empty shifter plus waiting byte: load, send start, data, parity if enabled, stop.
// - Holding register accepts next byte once shifter loaded.
// - Parity enable, parity type and transmit-complete status provided.
// - Transmit bit time is eight ticks of selected clock.
// - Transmit mode ignores the data input entirely.
// - Transmit interrupt on holding-empty, or on complete when selected.
// - Holding-empty interrupts only after a first byte is written.
// - Status read clears all but holding-empty and receive-full; byte write clears holding-empty.
// - Interrupt service alone clears nothing; set status suppresses more.
// - SPI master: full-duplex eight bits, clock made here, four modes.
// - SPI write while idle starts a transfer.
// - One bit out per bit in; after eight, swap bytes together.
// - Serial clock is selected clock divided by two, half duty.
// - Only data out and serial clock driven; no slave select.
// - SPI interrupt on holding-empty, or on transfer-complete when selected.
// - SPI status read clears all but holding-empty and receive-full.
// - SPI status cleared by read or write only; set status suppresses.
// - Receiver strips start and stop bits, checks configurable parity.
// - Receiver samples input with clock at eight times bit rate.
// - Receiver shifts bits in, then moves byte to holding register.
module scusm_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [1:0] i_func,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_int_en,
  input wire logic i_int_sel,
  input wire logic [1:0] i_spi_mode,
  input wire logic i_bit_clk,
  input wire logic i_rx_serial,
  input wire logic i_miso,
  input wire logic i_tx_write,
  input wire logic [7:0] i_tx_data,
  input wire logic i_rx_read,
  input wire logic i_status_read,
  output logic [7:0] o_rx_data,
  output logic [7:0] o_status,
  output logic o_irq,
  output logic o_serial_out,
  output logic o_sclk
);
  import scusm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    scusm_state_t st;
    logic [2:0] sub;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] rx_hold;
    logic [7:0] status;
    logic armed;
    logic rbit;
    logic ser;
    logic sclk;
    logic irq;
    logic ck1;
    logic ck2;
    logic ck_prev;
    logic rx1;
    logic rx2;
    logic mi1;
    logic mi2;
  } scusm_regs_t;

  scusm_regs_t q;
  scusm_regs_t next_q;
  logic tick;
  logic cpol;
  logic cpha;
  logic [7:0] set;
  logic [7:0] spi_byte;
  logic load_ok;
  logic irq_src;

  assign cpol = i_spi_mode[1];
  assign cpha = i_spi_mode[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_q = q;
    set = 8'h00;
    spi_byte = {q.shift[6:0], (cpha ? q.mi2 : q.rbit)};
    tick = q.ck2 & ~q.ck_prev;
    // A write in the same cycle wins the holding register; load waits
    load_ok = q.tx_full & ~i_tx_write;
    next_q.ck1 = i_bit_clk;
    next_q.ck2 = q.ck1;
    next_q.ck_prev = q.ck2;
    next_q.rx1 = i_rx_serial;
    next_q.rx2 = q.rx1;
    next_q.mi1 = i_miso;
    next_q.mi2 = q.mi1;

    if (!i_enable) begin
      next_q.st = ST_IDLE;
      next_q.ser = (i_func != FN_SPI);
      next_q.sclk = (i_func == FN_SPI) ? cpol : 1'b0;
    end else begin
      case (i_func)
        FN_TX: begin
          // Receive input unused here
          next_q.sclk = 1'b0;
          case (q.st)
            ST_IDLE: begin
              next_q.ser = 1'b1;
              if (load_ok) begin
                next_q.shift = q.tx_hold;
                next_q.tx_full = 1'b0;
                set[ST_TXE] = 1'b1;
                next_q.rbit = (^q.tx_hold) ^ i_parity_odd;
                next_q.st = ST_START;
                next_q.sub = 3'h0;
                next_q.ser = 1'b0;
              end
            end
            default: begin
              if (tick) begin
                next_q.sub = q.sub + 3'h1;
                if (q.sub == OVERSAMPLE_LAST) begin
                  case (q.st)
                    ST_START: begin
                      next_q.st = ST_DATA;
                      next_q.cnt = 4'h0;
                      next_q.ser = q.shift[0];
                    end
                    ST_DATA: begin
                      if (q.cnt == DATA_BIT_LAST) begin
                        next_q.st = i_parity_en ? ST_PARITY : ST_STOP;
                        next_q.ser = i_parity_en ? q.rbit : 1'b1;
                      end else begin
                        next_q.cnt = q.cnt + 4'h1;
                        next_q.shift = {1'b0, q.shift[7:1]};
                        next_q.ser = q.shift[1];
                      end
                    end
                    ST_PARITY: begin
                      next_q.st = ST_STOP;
                      next_q.ser = 1'b1;
                    end
                    default: begin
                      next_q.st = ST_IDLE;
                      set[ST_DONE] = 1'b1;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        FN_SPI: begin
          case (q.st)
            ST_DATA: begin
              if (tick) begin
                next_q.sclk = ~q.sclk;
                next_q.cnt = q.cnt + 4'h1;
                if (q.cnt[0] == cpha) begin
                  next_q.rbit = q.mi2;
                end else begin
                  if (q.cnt != 4'h0 || !cpha) begin
                    next_q.shift = {q.shift[6:0], q.rbit};
                  end
                  next_q.ser = (cpha && q.cnt == 4'h0) ? q.shift[7] :
                    q.shift[6];
                end
                if (q.cnt == SPI_EDGE_LAST) begin
                  next_q.rx_hold = spi_byte;
                  set[ST_RXF] = 1'b1;
                  set[ST_DONE] = 1'b1;
                  set[ST_OVR] = q.status[ST_RXF];
                  next_q.st = ST_IDLE;
                  if (load_ok) begin
                    next_q.shift = q.tx_hold;
                    next_q.tx_full = 1'b0;
                    set[ST_TXE] = 1'b1;
                    next_q.st = ST_DATA;
                    next_q.cnt = 4'h0;
                    next_q.ser = cpha ? q.ser : q.tx_hold[7];
                  end
                end
              end
            end
            default: begin
              next_q.st = ST_IDLE;
              next_q.sclk = cpol;
              if (load_ok) begin
                next_q.shift = q.tx_hold;
                next_q.tx_full = 1'b0;
                set[ST_TXE] = 1'b1;
                next_q.st = ST_DATA;
                next_q.cnt = 4'h0;
                next_q.ser = cpha ? q.ser : q.tx_hold[7];
              end
            end
          endcase
        end
        default: begin
          next_q.sclk = 1'b0;
          next_q.ser = 1'b1;
          case (q.st)
            ST_IDLE: begin
              if (!q.rx2) begin
                next_q.st = ST_START;
                next_q.sub = 3'h0;
              end
            end
            default: begin
              if (tick) begin
                next_q.sub = q.sub + 3'h1;
                if (q.sub == MID_SAMPLE) begin
                  case (q.st)
                    ST_START: begin
                      // Glitch shorter than half a bit is dropped
                      next_q.st = q.rx2 ? ST_IDLE : ST_DATA;
                      next_q.cnt = 4'h0;
                    end
                    ST_DATA: begin
                      next_q.shift = {q.rx2, q.shift[7:1]};
                      next_q.cnt = q.cnt + 4'h1;
                      if (q.cnt == DATA_BIT_LAST) begin
                        next_q.st = i_parity_en ? ST_PARITY : ST_STOP;
                      end
                    end
                    ST_PARITY: begin
                      set[ST_PE] = q.rx2 ^ (^q.shift) ^ i_parity_odd;
                      next_q.st = ST_STOP;
                    end
                    default: begin
                      set[ST_FE] = ~q.rx2;
                      next_q.rx_hold = q.shift;
                      set[ST_RXF] = 1'b1;
                      set[ST_OVR] = q.status[ST_RXF];
                      next_q.st = ST_IDLE;
                    end
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end

    // CPU side; hardware sets beat clears in the same cycle
    if (i_status_read) begin
      next_q.status = q.status & STATUS_KEEP;
    end
    if (i_rx_read) begin
      next_q.status[ST_RXF] = 1'b0;
    end
    if (i_tx_write) begin
      next_q.tx_hold = i_tx_data;
      next_q.tx_full = 1'b1;
      next_q.status[ST_TXE] = 1'b0;
      next_q.armed = 1'b1;
    end
    next_q.status = next_q.status | set;

    // Level interrupt: held while source status stays set
    if (i_func == FN_RX) begin
      irq_src = next_q.status[ST_RXF];
    end else if (i_int_sel) begin
      irq_src = next_q.status[ST_DONE];
    end else begin
      irq_src = next_q.status[ST_TXE] & next_q.armed;
    end
    next_q.irq = i_enable & i_int_en & irq_src;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '{st: ST_IDLE, sub: 3'h0, cnt: 4'h0, shift: BYTE_RESET,
        tx_hold: BYTE_RESET, tx_full: 1'b0, rx_hold: BYTE_RESET,
        status: STATUS_RESET, armed: 1'b0, rbit: 1'b0, ser: 1'b1,
        sclk: 1'b0, irq: 1'b0, ck1: 1'b0, ck2: 1'b0, ck_prev: 1'b0,
        rx1: 1'b1, rx2: 1'b1, mi1: 1'b0, mi2: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // Of the serial lines, only data out and clock leave the block
  assign o_rx_data = q.rx_hold;
  assign o_status = q.status;
  assign o_irq = q.irq;
  assign o_serial_out = q.ser;
  assign o_sclk = q.sclk;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  chk_rx_irq_hold: assert property (
    $past(i_enable && i_int_en && i_func == FN_RX && next_q.status[ST_RXF])
    |-> o_irq) else $error("rx irq not raised");
  chk_rxf_keep: assert property (
    (i_func == FN_RX && q.status[ST_RXF] && i_status_read && !i_rx_read)
    |=> q.status[ST_RXF]) else $error("rx full lost on status read");
  chk_rxf_clear: assert property (
    (i_func == FN_RX && q.st == ST_IDLE && i_rx_read) |=> !q.status[ST_RXF])
    else $error("rx full not cleared by data read");
  chk_fe_flag: assert property (
    (i_enable && i_func == FN_RX && q.st == ST_STOP && tick &&
    q.sub == MID_SAMPLE && !q.rx2) |=> q.status[ST_FE])
    else $error("framing error missed");
  chk_tx_start: assert property (
    (i_enable && i_func == FN_TX && q.st == ST_IDLE && load_ok)
    |=> (o_serial_out == 1'b0 && q.st == ST_START && q.status[ST_TXE]
    && !q.tx_full)) else $error("tx start bit or refill wrong");
  chk_tx_bit_time: assert property (
    (i_enable && i_func == FN_TX && q.st == ST_START && tick &&
    q.sub == OVERSAMPLE_LAST) |=> (q.st == ST_DATA &&
    o_serial_out == $past(q.shift[0]))) else $error("tx first bit wrong");
  chk_txe_write: assert property (
    i_tx_write |=> (!q.status[ST_TXE] && q.tx_full))
    else $error("holding empty not cleared by write");
  chk_done_clear: assert property (
    (i_func == FN_TX && q.st != ST_STOP && i_status_read)
    |=> !q.status[ST_DONE]) else $error("complete not cleared by read");
  chk_tx_irq_sel: assert property (
    $past(i_enable && i_int_en && i_func == FN_TX && i_int_sel &&
    next_q.status[ST_DONE]) |-> o_irq) else $error("complete irq missing");
  chk_unarmed: assert property (
    $past(i_func != FN_RX && !i_int_sel && !next_q.armed) |-> !o_irq)
    else $error("empty irq before first write");
  chk_sclk_idle: assert property (
    (i_enable && i_func == FN_SPI && q.st == ST_IDLE)
    |=> o_sclk == $past(cpol)) else $error("sclk idle level wrong");
  chk_sclk_div: assert property (
    (i_enable && i_func == FN_SPI && q.st == ST_DATA && tick)
    |=> o_sclk != $past(o_sclk)) else $error("sclk not toggled");
  chk_spi_swap: assert property (
    (i_enable && i_func == FN_SPI && q.st == ST_DATA && tick &&
    q.cnt == SPI_EDGE_LAST) |=> (q.status[ST_RXF] && q.status[ST_DONE]
    && o_rx_data == $past(spi_byte))) else $error("spi byte not moved");

  cov_rx_byte: cover property (i_func == FN_RX && $rose(q.status[ST_RXF]));
  cov_tx_done: cover property (i_func == FN_TX && $rose(q.status[ST_DONE]));
  cov_spi_back: cover property (i_func == FN_SPI && q.st == ST_DATA &&
    tick && q.cnt == SPI_EDGE_LAST && load_ok);
  cov_fe: cover property ($rose(q.status[ST_FE]));

endmodule

//--- sim/scusm_peer.sv
// Far side of the serial block: a remote UART sender and an SPI slave.
// Assumes the bench calls send and spi_load between transfers.
module scusm_peer (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic [1:0] i_mode,
  output logic o_rx_line,
  output logic o_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // UART sender and SPI slave
  // ****************************************************************
  localparam realtime BIT_NS = 640.0;
  logic [7:0] sh;
  logic [7:0] got;
  int edges;
  logic gap_bad;
  realtime last;
  initial begin
    o_rx_line = 1'b1;
    o_miso = 1'b0;
    sh = 8'h00;
    got = 8'h00;
    edges = 0;
    gap_bad = 1'b0;
    last = 0.0;
  end
  task automatic send(input logic [7:0] d, input logic pen,
                      input logic pbit, input logic stop);
    o_rx_line = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      o_rx_line = d[i];
      #BIT_NS;
    end
    if (pen) begin
      o_rx_line = pbit;
      #BIT_NS;
    end
    o_rx_line = stop;
    #BIT_NS;
    o_rx_line = 1'b1;
  endtask
  task automatic spi_load(input logic [7:0] rep);
    sh = rep;
    o_miso = rep[7];
    got = 8'h00;
    edges = 0;
    gap_bad = 1'b0;
  endtask
  // Sample 1 ns late so the master's data has landed
  always @(i_sclk) begin
    #1;
    if (edges > 0 && ($realtime - last < 70.0 || $realtime - last > 90.0))
      gap_bad = 1'b1;
    last = $realtime;
    edges = edges + 1;
    if ((i_sclk != i_mode[1]) != i_mode[0]) begin
      got = {got[6:0], i_mosi};
    end else if (i_mode[0]) begin
      o_miso = sh[7];
      sh = {sh[6:0], 1'b0};
    end else begin
      sh = {sh[6:0], 1'b0};
      o_miso = sh[7];
    end
  end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the serial block in RX, TX and SPI modes.
// Assumes scusm_pkg is compiled first and the peer model beside it.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scusm_pkg::*;
  // ****************************************************************
  // Signals, clocks, peer and design
  // ****************************************************************
  logic i_clk, i_reset, i_enable, i_parity_en, i_parity_odd, i_int_en;
  logic i_int_sel, i_bit_clk, i_rx_serial, i_miso, i_tx_write;
  logic i_rx_read, i_status_read, o_irq, o_serial_out, o_sclk;
  logic [1:0] i_func, i_spi_mode;
  logic [7:0] i_tx_data, o_rx_data, o_status;
  int failures = 0;
  int compares = 0;
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Bit clock at one eighth of i_clk, inside the sync limit
  initial begin
    i_bit_clk = 1'b0;
    #3;
    forever #40 i_bit_clk = ~i_bit_clk;
  end
  scusm_peer i_peer (.i_sclk(o_sclk), .i_mosi(o_serial_out),
    .i_mode(i_spi_mode), .o_rx_line(i_rx_serial), .o_miso(i_miso));
  scusm_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_enable(i_enable),
    .i_func(i_func), .i_parity_en(i_parity_en),
    .i_parity_odd(i_parity_odd), .i_int_en(i_int_en),
    .i_int_sel(i_int_sel), .i_spi_mode(i_spi_mode),
    .i_bit_clk(i_bit_clk), .i_rx_serial(i_rx_serial), .i_miso(i_miso),
    .i_tx_write(i_tx_write), .i_tx_data(i_tx_data),
    .i_rx_read(i_rx_read), .i_status_read(i_status_read),
    .o_rx_data(o_rx_data), .o_status(o_status), .o_irq(o_irq),
    .o_serial_out(o_serial_out), .o_sclk(o_sclk));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic report_and_stop;
    $display("Counts: %0d failures, %0d compares", failures, compares);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic setup(input logic [1:0] f, input logic pe, input logic po,
                       input logic sel, input logic [1:0] m);
    @(posedge i_clk);
    i_func <= f;
    i_parity_en <= pe;
    i_parity_odd <= po;
    i_int_sel <= sel;
    i_spi_mode <= m;
    @(posedge i_clk);
    #1;
  endtask
  task automatic strobe(input logic s, input logic r);
    @(posedge i_clk);
    i_status_read <= s;
    i_rx_read <= r;
    @(posedge i_clk);
    i_status_read <= 1'b0;
    i_rx_read <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge i_clk);
    i_tx_write <= 1'b1;
    i_tx_data <= d;
    @(posedge i_clk);
    i_tx_write <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wait_st(input int b, input int lim);
    int n;
    n = 0;
    while (o_status[b] !== 1'b1 && n < lim) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(8'(o_status[b]), 8'h01, "status bit wait");
  endtask
  // Samples mid-bit, so one tick of start jitter is harmless
  task automatic tx_frame(input logic [7:0] d);
    int n;
    n = 0;
    while (o_serial_out !== 1'b0 && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    #320;
    chk({7'h0, o_serial_out}, 8'h00, "start bit");
    for (int i = 0; i < 8; i++) begin
      #640;
      chk({7'h0, o_serial_out}, {7'h0, d[i]}, "data bit");
    end
    #640;
    chk({7'h0, o_serial_out}, {7'h0, ~^d}, "odd parity");
    #640;
    chk({7'h0, o_serial_out}, 8'h01, "stop bit");
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_rx;
    setup(FN_RX, 1'b0, 1'b0, 1'b0, 2'h0);
    i_peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
    wait_st(ST_RXF, 100);
    chk(o_rx_data, 8'hA5, "rx byte");
    chk({7'h0, o_irq}, 8'h01, "rx irq");
    strobe(1'b1, 1'b0);
    chk(o_status & 8'h04, 8'h04, "rx full kept");
    chk({7'h0, o_irq}, 8'h01, "rx irq held");
    strobe(1'b0, 1'b1);
    chk(o_status & 8'h04, 8'h00, "rx full cleared");
    chk({7'h0, o_irq}, 8'h00, "rx irq cleared");
    setup(FN_RX, 1'b1, 1'b0, 1'b0, 2'h0);
    i_peer.send(8'h03, 1'b1, 1'b1, 1'b1);
    wait_st(ST_RXF, 100);
    chk(o_status & 8'h1C, 8'h0C, "parity error");
    strobe(1'b1, 1'b1);
    chk(o_status & 8'h1C, 8'h00, "status cleared");
    setup(FN_RX, 1'b0, 1'b0, 1'b0, 2'h0);
    i_peer.send(8'h81, 1'b0, 1'b0, 1'b0);
    wait_st(ST_RXF, 100);
    chk(o_status & 8'h10, 8'h10, "framing error");
    chk(o_rx_data, 8'h81, "rx byte");
  endtask
  task automatic t_tx;
    do_reset;
    setup(FN_TX, 1'b1, 1'b1, 1'b0, 2'h0);
    chk(o_status, 8'h01, "reset status");
    chk({6'h0, o_irq, o_serial_out}, 8'h01, "idle, no irq");
    wr(8'h3C);
    wait_st(ST_TXE, 40);
    wr(8'hC3);
    chk(o_status & 8'h01, 8'h00, "holding full");
    fork
      i_peer.send(8'h55, 1'b0, 1'b0, 1'b1);
    join_none
    tx_frame(8'h3C);
    tx_frame(8'hC3);
    strobe(1'b1, 1'b0);
    chk(o_status & 8'h02, 8'h00, "first done cleared");
    wait_st(ST_DONE, 100);
    chk(o_status & 8'h07, 8'h03, "done, rx idle");
    chk({7'h0, o_irq}, 8'h01, "empty irq");
    setup(FN_TX, 1'b1, 1'b1, 1'b1, 2'h0);
    chk({7'h0, o_irq}, 8'h01, "complete irq");
    strobe(1'b1, 1'b0);
    chk(o_status & 8'h03, 8'h01, "empty kept");
    chk({7'h0, o_irq}, 8'h00, "irq gone");
  endtask
  task automatic t_spi;
    logic [1:0] m;
    logic [7:0] rep;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      rep = 8'h5A ^ {6'h0, m};
      do_reset;
      setup(FN_SPI, 1'b0, 1'b0, m[0], m);
      repeat (4) @(posedge i_clk);
      #1;
      chk({7'h0, o_sclk}, {7'h0, m[1]}, "sclk idle");
      chk({7'h0, o_irq}, 8'h00, "spi irq before write");
      i_peer.spi_load(rep);
      wr(8'hC6 ^ {6'h0, m});
      wait_st(ST_DONE, 400);
      #1; // Peer takes its last sample 1 ns after the edge
      chk(o_rx_data, rep, "spi rx byte");
      chk(i_peer.got, 8'hC6 ^ {6'h0, m}, "spi tx byte");
      chk(8'(i_peer.edges), 8'h10, "sclk edges");
      chk({7'h0, i_peer.gap_bad}, 8'h00, "half period");
      chk(o_status & 8'h07, 8'h07, "spi status");
      chk({7'h0, o_irq}, 8'h01, "spi irq");
      strobe(1'b1, 1'b0);
      chk(o_status & 8'h07, 8'h05, "spi read");
      chk({7'h0, o_irq}, {7'h0, ~m[0]}, "spi irq after read");
      strobe(1'b0, 1'b1);
      chk(o_status & 8'h07, 8'h01, "rx read");
    end
  endtask
  initial begin
    i_reset = 1'b1;
    i_enable = 1'b1;
    i_func = FN_RX;
    i_parity_en = 1'b0;
    i_parity_odd = 1'b0;
    i_int_en = 1'b1;
    i_int_sel = 1'b0;
    i_spi_mode = 2'h0;
    i_tx_write = 1'b0;
    i_tx_data = 8'h00;
    i_rx_read = 1'b0;
    i_status_read = 1'b0;
    do_reset;
    t_rx;
    t_tx;
    t_spi;
    report_and_stop;
  end
  initial begin
    #300us;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule
